// >>> verilog/mid_core.sv
// Top of the move instruction decoder: decodes and executes one move per clock.
// Assumes program memory returns INSTR for PROG_ADDR in the same cycle and data
// memory answers DMEM_RDATA for DMEM_ADDR combinationally; both share CLK.

// Contract
// - Every instruction is one fixed sixteen-bit word acting on registers.
// - The top bit chooses immediate or register interpretation of the source.
// - The low byte is the transfer source.
// - Register source: low nibble module, high nibble register index.
// - Bits eight to fourteen are the destination, always a register.
// - Destination: low four bits module, upper three bits subindex.
// - Upper 24 destinations need a prior prefix write, costing one cycle.
// - Fetch and execute complete in one clock with no pipeline.
// - Sixteen sixteen-bit accumulators are usable with any other register.
// - A sixteen-entry hardware return stack serves calls and task switches.
// - Three independent data memory pointers are provided.
// - Each pointer can step up or down itself after an access; a data write lands at the already stepped address.
// - Reads or writes of certain registers cause side effects.
// - Every operation is a move; source and destination select it.
// - Arithmetic and logic take any register with the active accumulator.
// - Peripheral registers are grouped into numbered modules.
// - Reset loads the stack index with the top of the stack.
// - Push raises index then stores; pop reads then lowers index.
module mid_core (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [15:0] INSTR,
    input wire logic [15:0] DMEM_RDATA,
    output logic [15:0] PROG_ADDR,
    output logic [15:0] DMEM_ADDR,
    output logic DMEM_WE,
    output logic [15:0] DMEM_WDATA,
    output mid_pkg::mid_pwr_t PERIPH_WR,
    output logic [3:0] STACK_INDEX,
    output logic CARRY
);

    // ==========================================================
    // Decode
    mid_pkg::mid_instr_t ins;
    logic [4:0] dst_idx;
    logic [15:0] src_val;
    logic src_pop;
    logic src_dmem;

    logic [15:0] acc [mid_pkg::NUM_ACC];
    logic [3:0] active;
    logic [1:0] prefix;
    logic [15:0] stk_rdata;
    logic [mid_pkg::NUM_PTR-1:0][15:0] ptr;
    logic [7:0] dp_ctrl;

    assign ins = mid_pkg::mid_instr_t'(INSTR);
    assign dst_idx = {prefix, ins.dst_sub};

    // Arithmetic and logic on the active accumulator; result with carry.
    function automatic logic [16:0] alu(input logic [4:0] op, input logic [15:0] a,
                                        input logic [15:0] b, input logic c);
        unique case (op)
            mid_pkg::ALU_ADD: alu = {1'b0, a} + {1'b0, b};
            mid_pkg::ALU_ADDC: alu = {1'b0, a} + {1'b0, b} + {16'h0000, c};
            mid_pkg::ALU_SUB: alu = {1'b0, a} - {1'b0, b};
            mid_pkg::ALU_AND: alu = {c, a & b};
            mid_pkg::ALU_OR: alu = {c, a | b};
            mid_pkg::ALU_XOR: alu = {c, a ^ b};
            default: alu = {c, a};
        endcase
    endfunction : alu

    // Source selection; only implemented registers yield data or side effects.
    always_comb
    begin
        src_val = mid_pkg::WORD_ZERO;
        src_pop = 1'b0;
        src_dmem = 1'b0;
        if (!ins.fmt)
        begin
            src_val = {8'h00, INSTR[7:0]};
        end
        else
        begin
            unique case (ins.src_mod)
                mid_pkg::MOD_ACC: src_val = acc[ins.src_idx];
                mid_pkg::MOD_ALU:
                begin
                    if ({1'b0, ins.src_idx} == mid_pkg::ALU_SEL)
                        src_val = {12'h000, active};
                    else if ({1'b0, ins.src_idx} == mid_pkg::ALU_STAT)
                        src_val = {15'h0000, CARRY};
                end
                mid_pkg::MOD_CTL:
                begin
                    if ({1'b0, ins.src_idx} == mid_pkg::CTL_PC)
                        src_val = PROG_ADDR;
                    else if ({1'b0, ins.src_idx} == mid_pkg::CTL_STACK)
                    begin
                        src_val = stk_rdata;
                        src_pop = 1'b1;
                    end
                    else if ({1'b0, ins.src_idx} == mid_pkg::CTL_SINDEX)
                        src_val = {12'h000, STACK_INDEX};
                end
                mid_pkg::MOD_DPT:
                begin
                    if (ins.src_idx < 4'(mid_pkg::NUM_PTR))
                        src_val = ptr[ins.src_idx[1:0]];
                    else if ({1'b0, ins.src_idx} == mid_pkg::DPT_CTRL)
                        src_val = {8'h00, dp_ctrl};
                    else if ({1'b0, ins.src_idx} == mid_pkg::DPT_DATA)
                    begin
                        src_val = DMEM_RDATA;
                        src_dmem = 1'b1;
                    end
                end
                default: src_val = mid_pkg::WORD_ZERO;
            endcase
        end
    end

    // ==========================================================
    // Execute: the destination write decides the operation
    logic [15:0] next_pc;
    logic [3:0] next_active;
    logic [1:0] next_prefix;
    logic next_carry;
    logic acc_we;
    logic [3:0] acc_wsel;
    logic [15:0] acc_wval;
    logic stk_push;
    logic [15:0] stk_wdata;
    logic [mid_pkg::NUM_PTR-1:0] dp_load;
    logic dp_ctrl_wr;
    logic dst_dmem;
    mid_pkg::mid_pwr_t next_pwr;
    logic [16:0] alu_res;

    assign alu_res = alu(dst_idx, acc[active], src_val, CARRY);

    // Destination decode with jump, call, prefix and peripheral effects.
    always_comb
    begin
        next_pc = PROG_ADDR + mid_pkg::WORD_ONE;
        next_active = active;
        next_prefix = 2'h0;
        next_carry = CARRY;
        acc_we = 1'b0;
        acc_wsel = active;
        acc_wval = src_val;
        stk_push = 1'b0;
        stk_wdata = src_val;
        dp_load = '0;
        dp_ctrl_wr = 1'b0;
        dst_dmem = 1'b0;
        next_pwr = '0;
        unique case (ins.dst_mod)
            mid_pkg::MOD_ACC:
            begin
                if (dst_idx < 5'(mid_pkg::NUM_ACC))
                begin
                    acc_we = 1'b1;
                    acc_wsel = dst_idx[3:0];
                end
            end
            mid_pkg::MOD_ALU:
            begin
                if (dst_idx == mid_pkg::ALU_SEL)
                    next_active = src_val[3:0];
                else if (dst_idx <= mid_pkg::ALU_XOR)
                begin
                    acc_we = 1'b1;
                    acc_wval = alu_res[15:0];
                    next_carry = alu_res[16];
                end
            end
            mid_pkg::MOD_CTL:
            begin
                if (dst_idx == mid_pkg::CTL_JUMP)
                    next_pc = src_val;
                else if (dst_idx == mid_pkg::CTL_STACK)
                    stk_push = 1'b1;
                else if (dst_idx == mid_pkg::CTL_CALL)
                begin
                    stk_push = 1'b1;
                    stk_wdata = PROG_ADDR + mid_pkg::WORD_ONE;
                    next_pc = src_val;
                end
                else if (dst_idx == mid_pkg::CTL_PREFIX)
                    next_prefix = src_val[1:0];
            end
            mid_pkg::MOD_DPT:
            begin
                if (dst_idx < 5'(mid_pkg::NUM_PTR))
                    dp_load[dst_idx[1:0]] = 1'b1;
                else if (dst_idx == mid_pkg::DPT_CTRL)
                    dp_ctrl_wr = 1'b1;
                else if (dst_idx == mid_pkg::DPT_DATA)
                    dst_dmem = 1'b1;
            end
            default:
            begin
                if (ins.dst_mod >= mid_pkg::MOD_PER_LO && ins.dst_mod <= mid_pkg::MOD_PER_HI)
                    next_pwr = '{we: 1'b1, mod: ins.dst_mod, idx: dst_idx,
                                 data: src_val};
            end
        endcase
    end

    // Architectural state, all updated in the one execute cycle.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            PROG_ADDR <= mid_pkg::PC_RESET;
            active <= 4'h0;
            prefix <= 2'h0;
            CARRY <= 1'b0;
            DMEM_WE <= 1'b0;
            DMEM_WDATA <= mid_pkg::WORD_ZERO;
            PERIPH_WR <= '0;
        end
        else if (CE)
        begin
            PROG_ADDR <= next_pc;
            active <= next_active;
            prefix <= next_prefix;
            CARRY <= next_carry;
            DMEM_WE <= dst_dmem;
            DMEM_WDATA <= src_val;
            PERIPH_WR <= next_pwr;
        end
    end

    // Accumulator file; written at most once per instruction.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            for (int unsigned i = 0; i < mid_pkg::NUM_ACC; i++)
                acc[i] <= mid_pkg::WORD_ZERO;
        end
        else if (CE && acc_we)
        begin
            acc[acc_wsel] <= acc_wval;
        end
    end

    // ==========================================================
    // Stack and data pointers
    mid_stack #(.DEPTH(mid_pkg::STACK_DEPTH)) u_stack (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .push(stk_push),
        .pop(src_pop),
        .wdata(stk_wdata),
        .rdata(stk_rdata),
        .stack_index(STACK_INDEX)
    );

    mid_dptr #(.NPTR(mid_pkg::NUM_PTR)) u_dptr (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .load(dp_load),
        .load_val(src_val),
        .ctrl_wr(dp_ctrl_wr),
        .ctrl_val(src_val[7:0]),
        .access(src_dmem || dst_dmem),
        .ptr(ptr),
        .ctrl(dp_ctrl),
        .addr(DMEM_ADDR)
    );

    // ==========================================================
    // Checks
    sequence prefix_write_seq;
        CE && ins.dst_mod == 4'hC && ins.dst_sub == 3'h3 && prefix == 2'h0;
    endsequence

    sequence next_instr_seq;
        CE [*1];
    endsequence

    prefix_once_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        prefix_write_seq ##1 next_instr_seq |=> prefix == 2'h0)
        else $error("prefix survived beyond one instruction");
    prefix_cost_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        prefix_write_seq |=> prefix == $past(src_val[1:0])
            && PROG_ADDR == $past(PROG_ADDR) + 16'h0001)
        else $error("prefix write did not take exactly one cycle");
    pc_step_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && ins.dst_mod != 4'hC |=> PROG_ADDR == $past(PROG_ADDR) + 16'h0001)
        else $error("plain move did not advance the program address by one");
    jump_target_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && ins.dst_mod == 4'hC && dst_idx == 5'h00 |=> PROG_ADDR == $past(src_val))
        else $error("jump did not load the program address");
    immediate_acc_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && !ins.fmt && ins.dst_mod == 4'h0 && prefix == 2'h0
        |=> acc[$past(INSTR[14:12])] == {8'h00, $past(INSTR[7:0])})
        else $error("immediate move did not reach the accumulator");
    unimpl_zero_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && ins.fmt && ins.src_mod == 4'h5 && ins.dst_mod == 4'h0 && prefix == 2'h0
        |=> acc[$past(INSTR[14:12])] == 16'h0000 && STACK_INDEX == $past(STACK_INDEX))
        else $error("unimplemented source gave data or a side effect");
    add_carry_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && ins.dst_mod == 4'h8 && dst_idx == 5'h01
        |=> {CARRY, acc[$past(active)]} == {1'b0, $past(acc[active])} + {1'b0, $past(src_val)})
        else $error("add result or carry wrong");
    call_push_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && ins.dst_mod == 4'hC && dst_idx == 5'h02
        |=> STACK_INDEX == $past(STACK_INDEX) + 4'h1 && stk_rdata == $past(PROG_ADDR) + 16'h0001)
        else $error("call did not save the return address");

endmodule : mid_core

// >>> verilog/mid_pkg.sv
// Shared constants, types and field layouts for the move instruction decoder.
// Assumes one core clock; program memory and data memory answer combinationally.
package mid_pkg;

    // ==========================================================
    // Instruction word layout
    typedef struct packed {
        logic fmt;            // High selects a register source, low an immediate.
        logic [2:0] dst_sub;  // Destination register subindex.
        logic [3:0] dst_mod;  // Destination module number.
        logic [3:0] src_idx;  // Source register index (register format).
        logic [3:0] src_mod;  // Source module number (register format).
    } mid_instr_t;

    // Peripheral write strobe group.
    typedef struct packed {
        logic we;
        logic [3:0] mod;
        logic [4:0] idx;
        logic [15:0] data;
    } mid_pwr_t;

    // ==========================================================
    // Module numbers
    localparam logic [3:0] MOD_ACC = 4'h0;
    localparam logic [3:0] MOD_PER_LO = 4'h1;
    localparam logic [3:0] MOD_PER_HI = 4'h7;
    localparam logic [3:0] MOD_ALU = 4'h8;
    localparam logic [3:0] MOD_CTL = 4'hC;
    localparam logic [3:0] MOD_DPT = 4'hD;

    // Arithmetic module register indices.
    localparam logic [4:0] ALU_SEL = 5'h00;
    localparam logic [4:0] ALU_ADD = 5'h01;
    localparam logic [4:0] ALU_ADDC = 5'h02;
    localparam logic [4:0] ALU_SUB = 5'h03;
    localparam logic [4:0] ALU_AND = 5'h04;
    localparam logic [4:0] ALU_OR = 5'h05;
    localparam logic [4:0] ALU_XOR = 5'h06;
    localparam logic [4:0] ALU_STAT = 5'h01;

    // Control module register indices.
    localparam logic [4:0] CTL_JUMP = 5'h00;
    localparam logic [4:0] CTL_STACK = 5'h01;
    localparam logic [4:0] CTL_CALL = 5'h02;
    localparam logic [4:0] CTL_PREFIX = 5'h03;
    localparam logic [4:0] CTL_SINDEX = 5'h04;
    localparam logic [4:0] CTL_PC = 5'h00;

    // Data pointer module register indices.
    localparam logic [4:0] DPT_CTRL = 5'h03;
    localparam logic [4:0] DPT_DATA = 5'h04;

    // Pointer step codes.
    localparam logic [1:0] STEP_NONE = 2'h0;
    localparam logic [1:0] STEP_INC = 2'h1;
    localparam logic [1:0] STEP_DEC = 2'h2;

    // ==========================================================
    // Reset values and counts
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [3:0] SINDEX_RESET = 4'hF;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam logic [4:0] DIRECT_DST_LIMIT = 5'h08;
    localparam int unsigned NUM_ACC = 16;
    localparam int unsigned STACK_DEPTH = 16;
    localparam int unsigned NUM_PTR = 3;

endpackage : mid_pkg

// >>> verilog/mid_stack.sv
// Sixteen-entry hardware return stack with its stack index.
// Assumes push and pop come from logic on the same clock.
module mid_stack #(
    parameter int unsigned DEPTH = mid_pkg::STACK_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic push,
    input wire logic pop,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output logic [3:0] stack_index
);

    // ==========================================================
    // Storage
    logic [15:0] mem [DEPTH];
    logic [3:0] next_stack_index;

    // The top entry is always visible so a pop reads before the index moves.
    assign rdata = mem[stack_index];

    // Push moves up then stores; pop reads then moves down; both replace the top.
    always_comb
    begin
        next_stack_index = stack_index;
        if (push && !pop)
        begin
            next_stack_index = stack_index + 4'h1;
        end
        else if (pop && !push)
        begin
            next_stack_index = stack_index - 4'h1;
        end
    end

    // Index register and entry write.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stack_index <= mid_pkg::SINDEX_RESET;
        end
        else if (ce)
        begin
            stack_index <= next_stack_index;
        end
    end

    // Entries carry no reset; a push stores at the freshly raised index.
    always_ff @(posedge clk)
    begin
        if (ce && push)
        begin
            mem[next_stack_index] <= wdata;
        end
    end

    // ==========================================================
    // Checks
    sequence push_seq;
        ce && push && !pop;
    endsequence

    reset_top_a: assert property (@(posedge clk) $rose(!rst) |-> stack_index == 4'hF)
        else $error("stack index not at top after reset");
    push_order_a: assert property (@(posedge clk) disable iff (rst)
        push_seq |=> stack_index == $past(stack_index) + 4'h1 && rdata == $past(wdata))
        else $error("push did not raise index then store");
    pop_order_a: assert property (@(posedge clk) disable iff (rst)
        ce && pop && !push |=> stack_index == $past(stack_index) - 4'h1)
        else $error("pop did not lower index");

endmodule : mid_stack

// >>> verilog/mid_dptr.sv
// Three data memory pointers with per-pointer automatic stepping.
// Assumes strobes come from logic on the same clock.
module mid_dptr #(
    parameter int unsigned NPTR = mid_pkg::NUM_PTR
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [NPTR-1:0] load,
    input wire logic [15:0] load_val,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_val,
    input wire logic access,
    output logic [NPTR-1:0][15:0] ptr,
    output logic [7:0] ctrl,
    output logic [15:0] addr
);

    // ==========================================================
    // Next pointer values
    logic [NPTR-1:0][15:0] next_ptr;
    logic [7:0] next_ctrl;
    logic [15:0] next_addr;
    logic [1:0] sel;

    assign sel = ctrl[1:0];

    // Step code of a pointer from the control byte.
    function automatic logic [1:0] step_of(input logic [7:0] c, input int unsigned i);
        step_of = c[2*i+2 +: 2];
    endfunction : step_of

    // Loads win; otherwise an access steps the active pointer by its mode.
    always_comb
    begin
        next_ptr = ptr;
        next_ctrl = ctrl_wr ? ctrl_val : ctrl;
        for (int unsigned i = 0; i < NPTR; i++)
        begin
            if (load[i])
            begin
                next_ptr[i] = load_val;
            end
            else if (access && sel == i[1:0])
            begin
                unique case (step_of(ctrl, i))
                    mid_pkg::STEP_INC: next_ptr[i] = ptr[i] + mid_pkg::WORD_ONE;
                    mid_pkg::STEP_DEC: next_ptr[i] = ptr[i] - mid_pkg::WORD_ONE;
                    default: next_ptr[i] = ptr[i];
                endcase
            end
        end
        next_addr = (next_ctrl[1:0] < NPTR[1:0]) ? next_ptr[next_ctrl[1:0]] : mid_pkg::WORD_ZERO;
    end

    // Pointer registers and the registered memory address.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ptr <= '0;
            ctrl <= 8'h00;
            addr <= mid_pkg::WORD_ZERO;
        end
        else if (ce)
        begin
            ptr <= next_ptr;
            ctrl <= next_ctrl;
            addr <= next_addr;
        end
    end

    // ==========================================================
    // Checks
    step_inc_a: assert property (@(posedge clk) disable iff (rst)
        ce && access && load == '0 && sel == 2'h0 && ctrl[3:2] == mid_pkg::STEP_INC
        |=> ptr[0] == $past(ptr[0]) + 16'h0001)
        else $error("active pointer did not step after access");

endmodule : mid_dptr

// >>> bench/mid_mem_model.sv
// Program and data memory model facing the move instruction decoder.
// Assumes one clock; both memories answer combinationally, writes land on the clock.
module mid_mem_model (
    input wire logic clk,
    input wire logic [15:0] prog_addr,
    output logic [15:0] instr,
    input wire logic [15:0] dmem_addr,
    input wire logic dmem_we,
    input wire logic [15:0] dmem_wdata,
    output logic [15:0] dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pmem [256];
    logic [15:0] dmem [256];
    // ==========================================================
    // Memories
    // Both arrays start cleared so the first fetch is a harmless move.
    initial
    begin
        foreach (pmem[i]) pmem[i] = 16'h0000;
        foreach (dmem[i]) dmem[i] = 16'h0000;
    end
    // Single fixed-width word per address, same cycle.
    assign instr = pmem[prog_addr[7:0]];
    assign dmem_rdata = dmem[dmem_addr[7:0]];
    // A data write lands on the clock edge while the strobe stands.
    always @(posedge clk)
    begin
        if (dmem_we)
        begin
            dmem[dmem_addr[7:0]] <= dmem_wdata;
        end
    end
endmodule : mid_mem_model

// >>> bench/tb.sv
// Self-checking bench for the move instruction decoder.
// Assumes the memory model answers fetches and data reads in the same cycle.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK;
    logic SYS_RST;
    logic CE;
    logic [15:0] INSTR;
    logic [15:0] DMEM_RDATA;
    logic [15:0] PROG_ADDR;
    logic [15:0] DMEM_ADDR;
    logic DMEM_WE;
    logic [15:0] DMEM_WDATA;
    mid_pkg::mid_pwr_t PERIPH_WR;
    logic [3:0] STACK_INDEX;
    logic CARRY;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    mid_core i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .INSTR(INSTR),
        .DMEM_RDATA(DMEM_RDATA), .PROG_ADDR(PROG_ADDR), .DMEM_ADDR(DMEM_ADDR),
        .DMEM_WE(DMEM_WE), .DMEM_WDATA(DMEM_WDATA), .PERIPH_WR(PERIPH_WR),
        .STACK_INDEX(STACK_INDEX), .CARRY(CARRY));
    mid_mem_model i_mem (.clk(CLK), .prog_addr(PROG_ADDR), .instr(INSTR),
        .dmem_addr(DMEM_ADDR), .dmem_we(DMEM_WE), .dmem_wdata(DMEM_WDATA),
        .dmem_rdata(DMEM_RDATA));
    // ==========================================================
    // Clock and timeout
    // The clock runs at 40 MHz; a hang ends the run after 2000 cycles.
    initial
    begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            final_report();
        end
    end
    // ==========================================================
    // Helpers
    // Builds a move word from format, destination subindex and module, and source.
    function automatic logic [15:0] mv(logic f, logic [2:0] s, logic [3:0] m, logic [7:0] src);
        return {f, s, m, src};
    endfunction : mv
    // Places a word at the current fetch address and lets one edge execute it.
    task automatic exec(logic [15:0] w);
        i_mem.pmem[PROG_ADDR[7:0]] = w;
        @(negedge CLK);
    endtask : exec
    // Compares one result with case equality and counts it.
    task automatic chk(string name, logic [25:0] exp, logic [25:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Moves a register source to peripheral module 1 and checks the strobe.
    task automatic show(logic [7:0] src, logic [15:0] d);
        exec(mv(1'b1, 3'h0, 4'h1, src));
        chk("periph_wr", {1'b1, 4'h1, 5'h00, d}, PERIPH_WR);
    endtask : show
    // ==========================================================
    // Scenarios
    // Reset state, then a frozen clock enable.
    task automatic t_reset();
        chk("stack_index", 26'h000_000F, 26'(STACK_INDEX));
        chk("prog_addr", 26'h000_0000, 26'(PROG_ADDR));
        chk("carry", 26'h000_0000, 26'(CARRY));
        SYS_RST = 1'b0;
        CE = 1'b0;
        exec(mv(1'b0, 3'h0, 4'hC, 8'h40));
        chk("prog_addr", 26'h000_0000, 26'(PROG_ADDR));
        CE = 1'b1;
        $display("test reset done");
    endtask : t_reset
    // Prefix reaches an upper accumulator for one instruction only.
    task automatic t_prefix();
        exec(mv(1'b0, 3'h3, 4'hC, 8'h01));
        exec(mv(1'b0, 3'h1, 4'h0, 8'h05));
        exec(mv(1'b0, 3'h1, 4'h0, 8'h07));
        show(8'h90, 16'h0005);
        show(8'h10, 16'h0007);
        $display("test prefix done");
    endtask : t_prefix
    // Arithmetic on the active accumulator with carry and borrow.
    task automatic t_alu();
        exec(mv(1'b0, 3'h0, 4'h8, 8'h01));
        exec(mv(1'b0, 3'h3, 4'h8, 8'h08));
        chk("carry", 26'h000_0001, 26'(CARRY));
        show(8'h10, 16'hFFFF);
        exec(mv(1'b1, 3'h1, 4'h8, 8'h90));
        chk("carry", 26'h000_0001, 26'(CARRY));
        show(8'h10, 16'h0004);
        exec(mv(1'b1, 3'h2, 4'h8, 8'h90));
        chk("carry", 26'h000_0000, 26'(CARRY));
        exec(mv(1'b0, 3'h5, 4'h8, 8'h30));
        exec(mv(1'b0, 3'h4, 4'h8, 8'h0F));
        exec(mv(1'b0, 3'h6, 4'h8, 8'hFF));
        show(8'h10, 16'h00F5);
        show(8'h08, 16'h0001);
        show(8'h18, 16'h0000);
        $display("test alu done");
    endtask : t_alu
    // Call, pop, jump and an unimplemented source.
    task automatic t_call();
        logic [15:0] ret;
        ret = PROG_ADDR + 16'h0001;
        exec(mv(1'b0, 3'h2, 4'hC, 8'h40));
        chk("prog_addr", 26'h000_0040, 26'(PROG_ADDR));
        chk("stack_index", 26'h000_0000, 26'(STACK_INDEX));
        show(8'h1C, ret);
        chk("stack_index", 26'h000_000F, 26'(STACK_INDEX));
        exec(mv(1'b0, 3'h0, 4'hC, 8'h10));
        chk("prog_addr", 26'h000_0010, 26'(PROG_ADDR));
        show(8'h5E, 16'h0000);
        show(8'h4C, 16'h000F);
        exec(mv(1'b0, 3'h1, 4'hC, 8'h77));
        show(8'h1C, 16'h0077);
        chk("stack_index", 26'h000_000F, 26'(STACK_INDEX));
        exec(mv(1'b1, 3'h1, 4'h0, 8'h55));
        show(8'h10, 16'h0000);
        $display("test call done");
    endtask : t_call
    // Two pointers stepping in opposite directions around reads and writes.
    task automatic t_dptr();
        i_mem.dmem[16] = 16'h1234;
        exec(mv(1'b0, 3'h0, 4'hD, 8'h10));
        exec(mv(1'b0, 3'h3, 4'hD, 8'h04));
        chk("dmem_addr", 26'h000_0010, 26'(DMEM_ADDR));
        show(8'h4D, 16'h1234);
        chk("dmem_addr", 26'h000_0011, 26'(DMEM_ADDR));
        exec(mv(1'b0, 3'h1, 4'hD, 8'h30));
        exec(mv(1'b0, 3'h3, 4'hD, 8'h21));
        exec(mv(1'b0, 3'h4, 4'hD, 8'hAB));
        chk("dmem_we", 26'h000_0001, 26'(DMEM_WE));
        chk("dmem_wdata", 26'h000_00AB, 26'(DMEM_WDATA));
        chk("dmem_addr", 26'h000_002F, 26'(DMEM_ADDR));
        exec(mv(1'b0, 3'h3, 4'hD, 8'h04));
        chk("dmem_we", 26'h000_0000, 26'(DMEM_WE));
        chk("dmem_addr", 26'h000_0011, 26'(DMEM_ADDR));
        show(8'h3D, 16'h0004);
        show(8'h0D, 16'h0011);
        show(8'h1D, 16'h002F);
        $display("test dptr done");
    endtask : t_dptr
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ==========================================================
    // Main sequence
    initial
    begin
        SYS_RST = 1'b1;
        CE = 1'b1;
        repeat (6) @(negedge CLK);
        t_reset();
        t_prefix();
        t_alu();
        t_call();
        t_dptr();
        final_report();
    end
endmodule : tb
